// ### inc/meas_quality_pkg.sv
// Constants, commands and carrier types of the measurement quality status group
`default_nettype none

package meas_quality_pkg;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int unsigned WORD_WIDTH = 16;

    localparam int unsigned BIT_OVER_RANGE   = 1;
    localparam int unsigned BIT_OVERLOAD     = 3;
    localparam int unsigned BIT_SELF_CHECK   = 4;
    localparam int unsigned BIT_BACKUP_BAD   = 5;
    localparam int unsigned BIT_REMOTE_CHG   = 6;
    localparam int unsigned BIT_CAL_EXPIRED  = 8;
    localparam int unsigned BIT_FATAL        = 14;

    // Bits that carry a condition; all others read as zero in the condition and event words
    localparam logic [15:0] USED_BITS_MASK = 16'h417a;

    // ------------------------------------------------------------------
    // Reset, preset and range values
    // ------------------------------------------------------------------
    localparam logic [15:0] ENABLE_DEFAULT = 16'h0000;
    localparam logic [15:0] RISE_DEFAULT   = 16'h7fff;
    localparam logic [15:0] FALL_DEFAULT   = 16'h0000;
    localparam logic [15:0] MASK_MAX       = 16'h7fff;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    // ------------------------------------------------------------------
    // Host commands
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_READ_EVENT     = 4'h0,
        CMD_READ_CONDITION = 4'h1,
        CMD_WRITE_ENABLE   = 4'h2,
        CMD_READ_ENABLE    = 4'h3,
        CMD_WRITE_RISE     = 4'h4,
        CMD_READ_RISE      = 4'h5,
        CMD_WRITE_FALL     = 4'h6,
        CMD_READ_FALL      = 4'h7,
        CMD_PRESET         = 4'h8
    } command_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        command_type code;
        logic [15:0] data;
    } request_type;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [15:0] data;
    } answer_type;

    typedef struct packed {
        logic fatal;
        logic cal_expired;
        logic remote_change;
        logic backup_bad;
        logic self_check;
        logic overload;
        logic over_range;
    } condition_type;

endpackage

`default_nettype wire

// ### hdl/meas_quality_status.sv
// Measurement quality status group: condition, transition filters, event and enable words
`timescale 1ns/1ns
`default_nettype none

module meas_quality_status #(
    parameter int unsigned WIDTH = meas_quality_pkg::WORD_WIDTH
) (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire meas_quality_pkg::condition_type condition_pins,
    input  wire meas_quality_pkg::request_type request,
    output var meas_quality_pkg::answer_type   answer,
    output logic                               summary,
    output logic                               preset_all
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic mask_in_range(input logic [15:0] value);
        mask_in_range = (value <= meas_quality_pkg::MASK_MAX);
    endfunction

    function automatic logic is_mask_write(input meas_quality_pkg::command_type code);
        is_mask_write = (code == meas_quality_pkg::CMD_WRITE_ENABLE) ||
                        (code == meas_quality_pkg::CMD_WRITE_RISE) ||
                        (code == meas_quality_pkg::CMD_WRITE_FALL);
    endfunction

    // ------------------------------------------------------------------
    // Condition synchroniser
    // ------------------------------------------------------------------
    meas_quality_pkg::condition_type sync1_q;
    meas_quality_pkg::condition_type sync1_d;
    meas_quality_pkg::condition_type sync2_q;
    meas_quality_pkg::condition_type sync2_d;

    always_comb begin
        sync1_d = condition_pins;
        sync2_d = sync1_q;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ------------------------------------------------------------------
    // Condition word
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] condition_q;
    logic [WIDTH-1:0] condition_d;
    logic [WIDTH-1:0] condition_prev_q;
    logic [WIDTH-1:0] condition_prev_d;

    always_comb begin
        condition_d = '0;
        condition_d[meas_quality_pkg::BIT_OVER_RANGE]  = sync2_q.over_range;
        condition_d[meas_quality_pkg::BIT_OVERLOAD]    = sync2_q.overload;
        condition_d[meas_quality_pkg::BIT_SELF_CHECK]  = sync2_q.self_check;
        condition_d[meas_quality_pkg::BIT_BACKUP_BAD]  = sync2_q.backup_bad;
        condition_d[meas_quality_pkg::BIT_REMOTE_CHG]  = sync2_q.remote_change;
        condition_d[meas_quality_pkg::BIT_CAL_EXPIRED] = sync2_q.cal_expired;
        condition_d[meas_quality_pkg::BIT_FATAL]       = sync2_q.fatal;
        condition_d = condition_d & meas_quality_pkg::USED_BITS_MASK[WIDTH-1:0];
        condition_prev_d = condition_q;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            condition_q      <= '0;
            condition_prev_q <= '0;
        end else begin
            condition_q      <= condition_d;
            condition_prev_q <= condition_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic take;
    logic write_ok;
    logic write_bad;
    logic read_event;
    logic do_preset;

    always_comb begin
        take       = request.valid;
        write_ok   = take && is_mask_write(request.code) && mask_in_range(request.data);
        write_bad  = take && is_mask_write(request.code) && !mask_in_range(request.data);
        read_event = take && (request.code == meas_quality_pkg::CMD_READ_EVENT);
        do_preset  = take && (request.code == meas_quality_pkg::CMD_PRESET);
    end

    // ------------------------------------------------------------------
    // Filter and enable masks
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] enable_q;
    logic [WIDTH-1:0] enable_d;
    logic [WIDTH-1:0] rise_q;
    logic [WIDTH-1:0] rise_d;
    logic [WIDTH-1:0] fall_q;
    logic [WIDTH-1:0] fall_d;

    always_comb begin
        enable_d = enable_q;
        rise_d   = rise_q;
        fall_d   = fall_q;
        if (do_preset) begin
            enable_d = meas_quality_pkg::ENABLE_DEFAULT[WIDTH-1:0];
            rise_d   = meas_quality_pkg::RISE_DEFAULT[WIDTH-1:0];
            fall_d   = meas_quality_pkg::FALL_DEFAULT[WIDTH-1:0];
        end else if (write_ok) begin
            unique case (request.code)
                meas_quality_pkg::CMD_WRITE_ENABLE: begin
                    enable_d = request.data[WIDTH-1:0];
                end
                meas_quality_pkg::CMD_WRITE_RISE: begin
                    rise_d = request.data[WIDTH-1:0];
                end
                meas_quality_pkg::CMD_WRITE_FALL: begin
                    fall_d = request.data[WIDTH-1:0];
                end
                default: begin
                    enable_d = enable_q;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= meas_quality_pkg::ENABLE_DEFAULT[WIDTH-1:0];
            rise_q   <= meas_quality_pkg::RISE_DEFAULT[WIDTH-1:0];
            fall_q   <= meas_quality_pkg::FALL_DEFAULT[WIDTH-1:0];
        end else begin
            enable_q <= enable_d;
            rise_q   <= rise_d;
            fall_q   <= fall_d;
        end
    end

    // ------------------------------------------------------------------
    // Event word
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] event_q;
    logic [WIDTH-1:0] event_d;
    logic [WIDTH-1:0] event_set;

    for (genvar i = 0; i < WIDTH; i++) begin : g_event
        always_comb begin
            event_set[i] = (condition_q[i] && !condition_prev_q[i] && rise_q[i]) ||
                           (!condition_q[i] && condition_prev_q[i] && fall_q[i]);
        end
    end

    always_comb begin
        // A new event in the clearing cycle survives the read
        event_d = (read_event ? '0 : event_q) | event_set;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            event_q <= '0;
        end else begin
            event_q <= event_d;
        end
    end

    // ------------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------------
    meas_quality_pkg::answer_type answer_q;
    meas_quality_pkg::answer_type answer_d;

    always_comb begin
        answer_d       = '0;
        answer_d.valid = take;
        answer_d.error = write_bad;
        if (take) begin
            unique case (request.code)
                meas_quality_pkg::CMD_READ_EVENT: begin
                    answer_d.data = 16'(event_q);
                end
                meas_quality_pkg::CMD_READ_CONDITION: begin
                    answer_d.data = 16'(condition_q);
                end
                meas_quality_pkg::CMD_READ_ENABLE: begin
                    answer_d.data = 16'(enable_q);
                end
                meas_quality_pkg::CMD_READ_RISE: begin
                    answer_d.data = 16'(rise_q);
                end
                meas_quality_pkg::CMD_READ_FALL: begin
                    answer_d.data = 16'(fall_q);
                end
                default: begin
                    answer_d.data = meas_quality_pkg::WORD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            answer_q <= '0;
        end else begin
            answer_q <= answer_d;
        end
    end

    // ------------------------------------------------------------------
    // Summary and preset fan-out
    // ------------------------------------------------------------------
    logic summary_q;
    logic summary_d;
    logic preset_q;
    logic preset_d;

    always_comb begin
        summary_d = |(event_d & enable_d);
        preset_d  = do_preset;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            summary_q <= 1'b0;
            preset_q  <= 1'b0;
        end else begin
            summary_q <= summary_d;
            preset_q  <= preset_d;
        end
    end

    always_comb begin
        answer     = answer_q;
        summary    = summary_q;
        preset_all = preset_q;
    end

endmodule

`default_nettype wire

// ### test/meas_quality_checker.sv
// Concurrent checks on the ports of the measurement quality status group
`timescale 1ns/1ns
`default_nettype none
module meas_quality_checker (
    input wire logic                            clock,
    input wire logic                            arst_n,
    input wire meas_quality_pkg::condition_type condition_pins,
    input wire meas_quality_pkg::request_type   request,
    input wire meas_quality_pkg::answer_type    answer,
    input wire logic                            summary,
    input wire logic                            preset_all
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [3:0]                      quiet_q;
    logic [3:0]                      quiet_d;
    meas_quality_pkg::condition_type pins_q;
    logic                            take_ev;
    logic                            take_cond;
    logic                            take_pre;
    logic                            take_rise;
    logic                            take_wr;
    assign take_ev = request.valid && request.code == meas_quality_pkg::CMD_READ_EVENT;
    assign take_cond = request.valid && request.code == meas_quality_pkg::CMD_READ_CONDITION;
    assign take_pre = request.valid && request.code == meas_quality_pkg::CMD_PRESET;
    assign take_rise = request.valid && request.code == meas_quality_pkg::CMD_READ_RISE;
    assign take_wr = request.valid && request.code inside {4'h2, 4'h4, 4'h6};
    always_comb begin
        quiet_d = (condition_pins != pins_q) ? 4'h0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            quiet_q <= 4'h0;
            pins_q  <= '0;
        end else begin
            quiet_q <= quiet_d;
            pins_q  <= condition_pins;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------------
    sequence s_read_event; take_ev; endsequence
    sequence s_read_cond; take_cond; endsequence
    sequence s_preset_gap; take_pre ##1 !request.valid; endsequence
    property p_answer_pulse; request.valid |=> answer.valid; endproperty
    property p_unused_zero;
        (take_ev || take_cond) |=> (answer.data & ~meas_quality_pkg::USED_BITS_MASK) == 16'h0000;
    endproperty
    property p_read_clears;
        s_read_event ##2 (s_read_event and (quiet_q > 4'h4)) |=> answer.data == 16'h0000;
    endproperty
    property p_cond_steady;
        s_read_cond ##2 (s_read_cond and (quiet_q > 4'h4)) |=> answer.data == $past(answer.data, 2);
    endproperty
    property p_refuse; (take_wr && request.data > meas_quality_pkg::MASK_MAX) |=> answer.error; endproperty
    property p_accept; (take_wr && request.data <= meas_quality_pkg::MASK_MAX) |=> !answer.error; endproperty
    property p_preset_pulse; take_pre |=> preset_all; endproperty
    property p_preset_only; !take_pre |=> !preset_all; endproperty
    property p_preset_rise;
        s_preset_gap ##1 take_rise |=> answer.data == meas_quality_pkg::RISE_DEFAULT;
    endproperty
    property p_summary_off;
        (request.valid && request.code == meas_quality_pkg::CMD_WRITE_ENABLE && request.data == 16'h0000)
            |=> !summary;
    endproperty
    a_answer_pulse: assert property (p_answer_pulse) else $error("no answer after request");
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set in word");
    a_read_clears: assert property (p_read_clears) else $error("event word not cleared by read");
    a_cond_steady: assert property (p_cond_steady) else $error("condition changed by read");
    a_refuse: assert property (p_refuse) else $error("oversize mask value accepted");
    a_accept: assert property (p_accept) else $error("legal mask value refused");
    a_preset_pulse: assert property (p_preset_pulse) else $error("preset pulse missing");
    a_preset_only: assert property (p_preset_only) else $error("preset pulse without preset");
    a_preset_rise: assert property (p_preset_rise) else $error("rise filter not preset");
    a_summary_off: assert property (p_summary_off) else $error("summary with empty enable");
endmodule
`default_nettype wire

// ### test/status_host.sv
// Remote host model issuing status commands to the group
`timescale 1ns/1ns
`default_nettype none
module status_host (
    input  wire logic                         clock,
    output var meas_quality_pkg::request_type request,
    input  wire meas_quality_pkg::answer_type answer
);
    initial begin
        request = '0;
    end
    // One command, entered just after a falling edge; released data is inverted
    // Answer stands one cycle only, so it is taken at the first falling edge
    task automatic cmd(input meas_quality_pkg::command_type code, input logic [15:0] data,
                       output meas_quality_pkg::answer_type ans);
        request.valid = 1'b1;
        request.code = code;
        request.data = data;
        @(negedge clock);
        ans = answer;
        request.valid = 1'b0;
        request.data = ~data;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ### test/meas_quality_status_bench.sv
// Self-checking bench of the measurement quality status group
`timescale 1ns/1ns
`default_nettype none
module meas_quality_status_bench;
    logic                            clock;
    logic                            arst_n;
    logic                            summary;
    logic                            preset_all;
    meas_quality_pkg::condition_type pins;
    meas_quality_pkg::request_type   request;
    meas_quality_pkg::answer_type    answer;
    meas_quality_pkg::answer_type    ans;
    meas_quality_pkg::command_type   wr_codes [3] = '{meas_quality_pkg::CMD_WRITE_ENABLE,
        meas_quality_pkg::CMD_WRITE_RISE, meas_quality_pkg::CMD_WRITE_FALL};
    int                              error_cnt = 0;
    int                              tests_run = 0;
    int                              cycles = 0;
    int                              preset_cnt = 0;
    meas_quality_status dut (.clock(clock), .arst_n(arst_n), .condition_pins(pins), .request(request),
        .answer(answer), .summary(summary), .preset_all(preset_all));
    status_host host (.clock(clock), .request(request), .answer(answer));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input meas_quality_pkg::command_type code, input logic [15:0] data, input logic [15:0] exp);
        host.cmd(code, data, ans);
        check(ans.data, exp);
    endtask
    task automatic drive(input logic [6:0] v);
        pins = v;
        repeat (5) @(negedge clock);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (preset_all === 1'b1) begin
            preset_cnt++;
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        pins = '0;
        arst_n = 1'b0;
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        run(meas_quality_pkg::CMD_READ_ENABLE, 16'h0000, 16'h0000);
        run(meas_quality_pkg::CMD_READ_RISE, 16'h0000, 16'h7fff);
        run(meas_quality_pkg::CMD_READ_FALL, 16'h0000, 16'h0000);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h0000);
        run(meas_quality_pkg::command_type'(4'h9), 16'h1234, 16'h0000);
        $display("test reset values done");
        foreach (wr_codes[i]) begin
            run(wr_codes[i], 16'h1234, 16'h0000);
            run(meas_quality_pkg::command_type'(wr_codes[i] + 4'h1), 16'h0000, 16'h1234);
            host.cmd(wr_codes[i], 16'h7fff, ans);
            check({15'h0000, ans.error}, 16'h0000);
            host.cmd(wr_codes[i], 16'h8000, ans);
            check({15'h0000, ans.error}, 16'h0001);
            run(meas_quality_pkg::command_type'(wr_codes[i] + 4'h1), 16'h0000, 16'h7fff);
        end
        $display("test mask access done");
        drive(7'h02);
        check({15'h0000, summary}, 16'h0001);
        run(meas_quality_pkg::CMD_READ_CONDITION, 16'h0000, 16'h0008);
        run(meas_quality_pkg::CMD_READ_CONDITION, 16'h0000, 16'h0008);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h0008);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h0000);
        check({15'h0000, summary}, 16'h0000);
        drive(7'h7f);
        run(meas_quality_pkg::CMD_READ_CONDITION, 16'h0000, 16'h417a);
        check(ans.data & 16'h4000, 16'h4000);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h4172);
        run(meas_quality_pkg::CMD_WRITE_RISE, 16'h0000, 16'h0000);
        drive(7'h00);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h417a);
        run(meas_quality_pkg::CMD_WRITE_FALL, 16'h0000, 16'h0000);
        drive(7'h7f);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h0000);
        $display("test transitions done");
        run(meas_quality_pkg::CMD_WRITE_FALL, 16'h0123, 16'h0000);
        drive(7'h00);
        check({15'h0000, summary}, 16'h0001);
        run(meas_quality_pkg::CMD_WRITE_ENABLE, 16'h0000, 16'h0000);
        check({15'h0000, summary}, 16'h0000);
        run(meas_quality_pkg::CMD_READ_EVENT, 16'h0000, 16'h0122);
        run(meas_quality_pkg::CMD_WRITE_ENABLE, 16'h0040, 16'h0000);
        host.cmd(meas_quality_pkg::CMD_PRESET, 16'h0000, ans);
        check(16'(preset_cnt), 16'h0001);
        run(meas_quality_pkg::CMD_READ_RISE, 16'h0000, 16'h7fff);
        run(meas_quality_pkg::CMD_READ_FALL, 16'h0000, 16'h0000);
        run(meas_quality_pkg::CMD_READ_ENABLE, 16'h0000, 16'h0000);
        $display("test preset done");
        print_verdict();
    end
endmodule
bind meas_quality_status meas_quality_checker chk (.clock(clock), .arst_n(arst_n), .condition_pins(condition_pins),
    .request(request), .answer(answer), .summary(summary), .preset_all(preset_all));
`default_nettype wire
